// file: design/mumac_dual_port_ram.sv
`timescale 1ns/1ps
// Word memory with two read ports and one write port
module mumac_dual_port_ram #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic clk_sys_i, // System clock
  input wire logic [AW-1:0] rd_a_addr_i, // Read port A address
  output logic [DW-1:0] rd_a_data_o, // Read port A data
  input wire logic [AW-1:0] rd_b_addr_i, // Read port B address
  output logic [DW-1:0] rd_b_data_o, // Read port B data
  input wire logic wr_en_i, // Write enable
  input wire logic [AW-1:0] wr_addr_i, // Write address
  input wire logic [DW-1:0] wr_data_i // Write data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Reads see the old word during a write to the same address
  assign rd_a_data_o = mem[rd_a_addr_i];
  assign rd_b_data_o = mem[rd_b_addr_i];

  // Storage has no reset, like a real RAM macro
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

endmodule // mumac_dual_port_ram

// file: design/mumac_pkg.sv
package mumac_pkg;

  // Instruction encoding, byte 0 is the lowest byte of the word
  localparam logic [7:0] OPC_PREFIX = 8'h93;
  localparam logic [7:0] OPC_U_ADD = 8'h18;
  localparam logic [7:0] OPC_U_SUB = 8'h28;
  localparam logic [7:0] OPC_U_RND = 8'h19;
  localparam logic [7:0] OPC_M_ADD = 8'h98;
  localparam logic [7:0] OPC_M_RND = 8'h99;
  localparam int BYTE0_LSB = 0;
  localparam int BYTE2_LSB = 16;

  // Datapath widths
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;
  localparam int ACC_W = 40;
  localparam int ACC_HI_W = 8;
  localparam int LOW_W = 16;
  localparam int FLAG_W = 7;

  // Rounding constant and saturation limits
  localparam logic [39:0] RND_CONST = 40'h00_0000_8000;
  localparam logic [39:0] SAT_MAX = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_MIN = 40'hFF_8000_0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

  // Flag bit positions in the flag vector and flag register
  localparam int FL_OVF = 0;
  localparam int FL_SLIM = 1;
  localparam int FL_EXT = 2;
  localparam int FL_SOVF = 3;
  localparam int FL_CARRY = 4;
  localparam int FL_ZERO = 5;
  localparam int FL_NEG = 6;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // Control register fields
  localparam int CTRL_SAT_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // APB register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_ACC_LO = 12'h008;
  localparam logic [11:0] ADDR_ACC_HI = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // Operation kinds, one-hot
  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_U_ADD = 6'b000010,
    OP_U_SUB = 6'b000100,
    OP_U_RND = 6'b001000,
    OP_M_ADD = 6'b010000,
    OP_M_RND = 6'b100000
  } mumac_op_t;

endpackage

// file: design/mumac_top.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
//
// Contract
// - Unsigned forms: 16x16 unsigned product, zero-extended to 40 bits.
// - Add form: accumulator plus extended product, stored back.
// - Subtract form: accumulator minus extended product, stored back.
// - Word at index pointer copied to a target set by pointer change.
// - Both operands read together from memory in the same operation.
// - Add forms: overflow flag set when 40-bit signed result overflows.
// - Subtract forms: overflow flag set on 40-bit signed underflow.
// - Sticky limit flag set when result saturates, else kept.
// - Extension flag set when extension byte holds significant bits.
// - Sticky overflow flag set on overflow or underflow, cleared only by a software write of one.
// - Carry flag set on carry or borrow out of 40 bits.
// - Zero flag set when the stored result is zero.
// - Negative flag equals bit 39 of the stored result.
// - Round form decoded as bytes 93, pointers, 19, pointers.
// - Round forms add 8000h to the sum before storing.
// - Rounded forms clear the low 16 accumulator bits; the code leaves them set when it clamps to SAT_MAX.
// - Mixed forms: first operand unsigned, second signed, sign-extended.
//
module mumac_top
  import mumac_pkg::*;
#(
  parameter int RAM_AW = 8
) (
  input wire logic clk_sys_i, // System clock, 25 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [APB_AW-1:0] paddr_i, // APB byte address
  input wire logic [APB_DW-1:0] pwdata_i, // APB write data
  output logic [APB_DW-1:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped address
  input wire logic instr_valid_i, // Decoded instruction present
  input wire logic [31:0] instr_i, // Four instruction bytes
  input wire logic [RAM_AW-1:0] index_pointer_i, // First operand address
  input wire logic [RAM_AW-1:0] operand_pointer_gpr_i, // Second operand
  input wire logic [RAM_AW-1:0] move_addr_i, // Modified index target
  input wire logic load_we_i, // Core memory load strobe
  input wire logic [RAM_AW-1:0] load_addr_i, // Core memory load address
  input wire logic [WORD_W-1:0] load_data_i, // Core memory load data
  output logic [ACC_W-1:0] acc_o, // Accumulator value
  output logic [FLAG_W-1:0] flags_o, // Flag vector
  output logic done_o, // Instruction retired, pulse
  output logic illegal_o, // Unknown opcode seen, pulse
  output logic move_pending_o // Memory write port busy next edge
);

  // True when the value fits a 32-bit signed number
  function automatic logic fits32(input logic [ACC_W-1:0] v);
    fits32 = (v[ACC_W-1:PROD_W-1] == '0) || (v[ACC_W-1:PROD_W-1] == '1);
  endfunction

  // Decode bytes 0 and 2 into an operation kind
  function automatic mumac_op_t decode(input logic [31:0] w);
    logic [7:0] b0;
    logic [7:0] b2;
    b0 = w[BYTE0_LSB +: 8];
    b2 = w[BYTE2_LSB +: 8];
    decode = OP_NONE;
    if (b0 == OPC_PREFIX) begin
      case (b2)
        OPC_U_ADD: decode = OP_U_ADD;
        OPC_U_SUB: decode = OP_U_SUB;
        OPC_U_RND: decode = OP_U_RND;
        OPC_M_ADD: decode = OP_M_ADD;
        OPC_M_RND: decode = OP_M_RND;
        default: decode = OP_NONE;
      endcase
    end
  endfunction

  // Registers
  logic [ACC_W-1:0] acc_q;
  logic [FLAG_W-1:0] flags_q;
  logic sat_en_q;
  logic [31:0] count_q;
  mumac_op_t op_q;
  logic [WORD_W-1:0] opa_q;
  logic [WORD_W-1:0] opb_q;
  logic [RAM_AW-1:0] mv_addr_q;
  logic done_q;
  logic illegal_q;
  logic move_pend_q;
  logic [APB_DW-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Memory wires
  logic [WORD_W-1:0] rd_a_data;
  logic [WORD_W-1:0] rd_b_data;
  logic ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [WORD_W-1:0] ram_wdata;

  // Datapath wires
  mumac_op_t op_dec;
  logic exec;
  logic is_sub;
  logic is_rnd;
  logic is_mix;
  logic [PROD_W-1:0] prod_u;
  logic [PROD_W:0] prod_m;
  logic [ACC_W-1:0] ext;
  logic [ACC_W-1:0] rnd;
  logic [ACC_W+1:0] wide;
  logic [ACC_W:0] carry_sum;
  logic ovf;
  logic [ACC_W-1:0] wrapped;
  logic sat_hit;
  logic [ACC_W-1:0] result;
  logic [FLAG_W-1:0] flags_d;

  // APB wires
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;
  logic [APB_DW-1:0] rd_mux;

  // Memory: the move uses the single write port, so it beats a core load
  assign ram_we = exec | load_we_i;
  assign ram_waddr = exec ? mv_addr_q : load_addr_i;
  assign ram_wdata = exec ? opa_q : load_data_i;

  mumac_dual_port_ram #(
    .AW(RAM_AW),
    .DW(WORD_W)
  ) u_ram (
    .clk_sys_i(clk_sys_i),
    .rd_a_addr_i(index_pointer_i),
    .rd_a_data_o(rd_a_data),
    .rd_b_addr_i(operand_pointer_gpr_i),
    .rd_b_data_o(rd_b_data),
    .wr_en_i(ram_we),
    .wr_addr_i(ram_waddr),
    .wr_data_i(ram_wdata)
  );

  assign op_dec = decode(instr_i);

  // Issue stage: both operands latched on the same edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_q <= OP_NONE;
      opa_q <= '0;
      opb_q <= '0;
      mv_addr_q <= '0;
    end else begin
      op_q <= instr_valid_i ? op_dec : OP_NONE;
      if (instr_valid_i) begin
        opa_q <= rd_a_data;
        opb_q <= rd_b_data;
        mv_addr_q <= move_addr_i;
      end
    end
  end

  // Operation kind decode for the execute stage
  always_comb begin
    exec = 1'b1;
    is_sub = 1'b0;
    is_rnd = 1'b0;
    is_mix = 1'b0;
    case (op_q)
      OP_U_ADD: exec = 1'b1;
      OP_U_SUB: is_sub = 1'b1;
      OP_U_RND: is_rnd = 1'b1;
      OP_M_ADD: is_mix = 1'b1;
      OP_M_RND: begin
        is_mix = 1'b1;
        is_rnd = 1'b1;
      end
      default: exec = 1'b0;
    endcase
  end

  // Products; the mixed one keeps a 33-bit signed form
  // Operands widened first so no tool can cut the product to 16 bits
  assign prod_u = {{WORD_W{1'b0}}, opa_q} *
                  {{WORD_W{1'b0}}, opb_q};
  assign prod_m = $signed({{(PROD_W+1-WORD_W){1'b0}}, opa_q}) *
                  $signed({{(PROD_W+1-WORD_W){opb_q[WORD_W-1]}}, opb_q});

  // Extension to accumulator width
  always_comb begin
    if (is_mix) begin
      ext = {{(ACC_W-PROD_W-1){prod_m[PROD_W]}}, prod_m};
    end else begin
      ext = {{(ACC_W-PROD_W){1'b0}}, prod_u};
    end
  end

  assign rnd = is_rnd ? RND_CONST : '0;

  // Two guard bits catch every signed overflow of the 40-bit sum
  always_comb begin
    if (is_sub) begin
      wide = {{2{acc_q[ACC_W-1]}}, acc_q} -
             {{2{ext[ACC_W-1]}}, ext};
      carry_sum = {1'b0, acc_q} - {1'b0, ext};
    end else begin
      wide = {{2{acc_q[ACC_W-1]}}, acc_q} +
             {{2{ext[ACC_W-1]}}, ext} +
             {{2{1'b0}}, rnd};
      carry_sum = {1'b0, acc_q} + {1'b0, ext} + {1'b0, rnd};
    end
  end

  // Overflow means the sum left the 40-bit signed range
  assign ovf = (wide[ACC_W+1:ACC_W-1] != '0) &&
               (wide[ACC_W+1:ACC_W-1] != '1);

  // Rounded forms drop the low word before any clamping
  always_comb begin
    wrapped = wide[ACC_W-1:0];
    if (is_rnd) begin
      wrapped[LOW_W-1:0] = '0;
    end
  end

  // Clamp on the true sign, which sits in the top guard bit
  assign sat_hit = sat_en_q && (ovf || !fits32(wrapped));
  always_comb begin
    if (sat_hit) begin
      result = wide[ACC_W+1] ? SAT_MIN : SAT_MAX;
    end else begin
      result = wrapped;
    end
  end

  // Flags; zero, negative and extension from the value actually stored
  always_comb begin
    flags_d = flags_q;
    flags_d[FL_OVF] = ovf;
    flags_d[FL_SLIM] = flags_q[FL_SLIM] | sat_hit;
    flags_d[FL_EXT] = !fits32(result);
    flags_d[FL_SOVF] = flags_q[FL_SOVF] | ovf;
    flags_d[FL_CARRY] = carry_sum[ACC_W];
    flags_d[FL_ZERO] = (result == '0);
    flags_d[FL_NEG] = result[ACC_W-1];
  end

  // APB decode; the slave answers in the first access cycle
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pready_q && pwrite_i;
  assign addr_ok = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_FLAGS) ||
                   (paddr_i == ADDR_ACC_LO) || (paddr_i == ADDR_ACC_HI) ||
                   (paddr_i == ADDR_COUNT);

  always_comb begin
    rd_mux = '0;
    case (paddr_i)
      ADDR_CTRL: rd_mux[CTRL_SAT_BIT] = sat_en_q;
      ADDR_FLAGS: rd_mux[FLAG_W-1:0] = flags_q;
      ADDR_ACC_LO: rd_mux = acc_q[APB_DW-1:0];
      ADDR_ACC_HI: rd_mux[ACC_HI_W-1:0] = acc_q[ACC_W-1:APB_DW];
      ADDR_COUNT: rd_mux = count_q;
      default: rd_mux = '0;
    endcase
  end

  // Read data and ready are captured in the setup cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !addr_ok;
      prdata_q <= (apb_setup && !pwrite_i) ? rd_mux : '0;
    end
  end

  // Saturation mode control
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sat_en_q <= CTRL_RESET[CTRL_SAT_BIT];
    end else if (apb_wr && paddr_i == ADDR_CTRL) begin
      sat_en_q <= pwdata_i[CTRL_SAT_BIT];
    end
  end

  // Accumulator: an executing instruction beats a software preload
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= ACC_RESET;
    end else if (exec) begin
      acc_q <= result;
    end else if (apb_wr && paddr_i == ADDR_ACC_LO) begin
      acc_q[APB_DW-1:0] <= pwdata_i;
    end else if (apb_wr && paddr_i == ADDR_ACC_HI) begin
      acc_q[ACC_W-1:APB_DW] <= pwdata_i[ACC_HI_W-1:0];
    end
  end

  // Flags; software clears sticky bits by writing one, an executing instruction wins
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_q <= FLAGS_RESET;
    end else if (exec) begin
      flags_q <= flags_d;
    end else if (apb_wr && paddr_i == ADDR_FLAGS) begin
      flags_q[FL_SLIM] <= flags_q[FL_SLIM] & ~pwdata_i[FL_SLIM];
      flags_q[FL_SOVF] <= flags_q[FL_SOVF] & ~pwdata_i[FL_SOVF];
    end
  end

  // Retired instruction count, wraps, cleared by any write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else if (apb_wr && paddr_i == ADDR_COUNT) begin
      count_q <= '0;
    end else if (exec) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // Status pulses to the core
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      move_pend_q <= 1'b0;
    end else begin
      done_q <= exec;
      illegal_q <= instr_valid_i && (op_dec == OP_NONE);
      move_pend_q <= instr_valid_i && (op_dec != OP_NONE);
    end
  end

  // Outputs straight from flops
  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign done_o = done_q;
  assign illegal_o = illegal_q;
  assign move_pending_o = move_pend_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

endmodule // mumac_top

// file: testbench/mumac_ram_model.sv
`timescale 1ns/1ps
// Core-side shadow of the word memory, loads and moves
module mumac_ram_model
  import mumac_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic load_we_i, // Load strobe
  input wire logic [7:0] load_addr_i, // Load address
  input wire logic [WORD_W-1:0] load_data_i, // Load data
  input wire logic instr_valid_i, // Issue
  input wire logic [31:0] instr_i, // Opcode bytes
  input wire logic [7:0] index_pointer_i, // Word to move
  input wire logic [7:0] move_addr_i // Move target
);
  int mem [256];
  bit due_q;
  int to_q;
  int word_q;
  // A due move owns the write port, so a load then is dropped
  always @(posedge clk_sys_i) begin
    if (due_q) mem[to_q] <= word_q;
    else if (load_we_i) mem[load_addr_i] <= int'(load_data_i);
    due_q <= instr_valid_i && instr_i[7:0] == OPC_PREFIX && instr_i[23:16]
      inside {OPC_U_ADD, OPC_U_SUB, OPC_U_RND, OPC_M_ADD, OPC_M_RND};
    to_q <= int'(move_addr_i);
    word_q <= mem[index_pointer_i];
  end
endmodule // mumac_ram_model

// file: testbench/mumac_top_properties.sv
`timescale 1ns/1ps
// Port-level properties of the accumulate block
module mumac_checker
  import mumac_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pwrite_i, // Write
  input wire logic [APB_AW-1:0] paddr_i, // Address
  input wire logic [APB_DW-1:0] pwdata_i, // Write data
  input wire logic pready_o, // Ready
  input wire logic instr_valid_i, // Issue
  input wire logic [31:0] instr_i, // Opcode bytes
  input wire logic [ACC_W-1:0] acc_o, // Accumulator
  input wire logic [FLAG_W-1:0] flags_o, // Flags
  input wire logic done_o, // Retired
  input wire logic illegal_o, // Refused
  input wire logic move_pending_o // Move due
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic ok;
  logic clr;
  // Known opcodes, and the write that may drop sticky flags
  assign ok = instr_i[7:0] == OPC_PREFIX && instr_i[23:16] inside
    {OPC_U_ADD, OPC_U_SUB, OPC_U_RND, OPC_M_ADD, OPC_M_RND};
  assign clr = psel_i && penable_i && pready_o && pwrite_i &&
    paddr_i == ADDR_FLAGS;
  sequence retire_s;
    move_pending_o ##1 done_o;
  endsequence
  issue_retire_a: assert property (
    instr_valid_i && ok |=> retire_s) else $error("not retired");
  bad_opcode_a: assert property (
    instr_valid_i && !ok |=> illegal_o && !move_pending_o)
    else $error("bad opcode taken");
  zero_flag_a: assert property (
    done_o |-> flags_o[FL_ZERO] == (acc_o == ACC_RESET)) else $error("zero");
  neg_flag_a: assert property (
    done_o |-> flags_o[FL_NEG] == acc_o[ACC_W-1]) else $error("negative");
  ext_flag_a: assert property (
    done_o |-> flags_o[FL_EXT] != (acc_o[39:31] inside {9'h000, 9'h1FF}))
    else $error("extension");
  sovf_set_a: assert property (
    done_o && flags_o[FL_OVF] |-> flags_o[FL_SOVF]) else $error("sticky");
  sovf_hold_a: assert property (
    $fell(flags_o[FL_SOVF]) |-> $past(clr && pwdata_i[FL_SOVF]))
    else $error("sticky overflow lost");
  slim_hold_a: assert property (
    $fell(flags_o[FL_SLIM]) |-> $past(clr && pwdata_i[FL_SLIM]))
    else $error("sticky limit lost");
  ovf_cause_a: assert property (
    $changed(flags_o[FL_OVF]) |-> done_o) else $error("overflow moved");
endmodule // mumac_checker

bind mumac_top mumac_checker chk (.clk_sys_i, .resetn_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .instr_valid_i,
  .instr_i, .acc_o, .flags_o, .done_o, .illegal_o, .move_pending_o);

// file: testbench/mumac_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin samples_checked++; if ((ac) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); end end
// Bench with a reference accumulator built from integers
module mumac_top_tb
  import mumac_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic resetn_i, psel_i, penable_i, pwrite_i, instr_valid_i, load_we_i;
  logic pready_o, pslverr_o, done_o, illegal_o, move_pending_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, instr_i, rd;
  logic [7:0] index_pointer_i, operand_pointer_gpr_i, move_addr_i;
  logic [7:0] load_addr_i;
  logic [15:0] load_data_i;
  logic [39:0] acc_o, acc_m;
  logic [6:0] flags_o, fl_m;
  logic [31:0] seed = 32'h0001_83A5;
  logic [7:0] ops [5] = '{OPC_U_ADD, OPC_U_SUB, OPC_U_RND, OPC_M_ADD,
    OPC_M_RND};
  int fails = 0;
  int samples_checked = 0;
  int cnt_m = 0;
  bit sat_m = 1'b0;

  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;

  mumac_top uut (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .instr_valid_i,
    .instr_i, .index_pointer_i, .operand_pointer_gpr_i, .move_addr_i,
    .load_we_i, .load_addr_i, .load_data_i, .acc_o, .flags_o, .done_o,
    .illegal_o, .move_pending_o);
  mumac_ram_model ram (.clk_sys_i, .load_we_i, .load_addr_i, .load_data_i,
    .instr_valid_i, .instr_i, .index_pointer_i, .move_addr_i);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; holds the request until ready is sampled high
  task automatic apb(input bit w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // No wait count here: only the watchdog ends a stuck transfer
    do @(posedge clk_sys_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic setacc(input logic [39:0] v);
    apb(1'b1, ADDR_ACC_LO, v[31:0]);
    apb(1'b1, ADDR_ACC_HI, {24'h00_0000, v[39:32]});
    acc_m = v;
  endtask

  // Reference step: product, sum, round, clamp, then flags
  task automatic mdl(input logic [7:0] opc, input int a, input int b);
    longint p, r, u, rc;
    logic [39:0] s;
    bit ov, big;
    p = opc[7] ? a * longint'(shortint'(b)) : a * longint'(b);
    rc = {48'h0, opc[0], 15'h0000};
    r = longint'(signed'(acc_m));
    u = longint'(acc_m);
    if (opc == OPC_U_SUB) begin
      r -= p;
      u -= p;
    end else begin
      r += p + rc;
      u += longint'(p[39:0]) + rc;
    end
    if (opc[0]) r[15:0] = 16'h0000;
    ov = (r >>> 39) != 0 && (r >>> 39) != -1;
    big = (r >>> 31) != 0 && (r >>> 31) != -1;
    s = r[39:0];
    if (sat_m && (ov || big)) begin
      s = r < 0 ? SAT_MIN : SAT_MAX;
      fl_m[FL_SLIM] = 1'b1;
    end
    fl_m[FL_OVF] = ov;
    fl_m[FL_SOVF] |= ov;
    fl_m[FL_CARRY] = u[40];
    fl_m[FL_EXT] = !(s[39:31] inside {9'h000, 9'h1FF});
    fl_m[FL_ZERO] = s == 40'h00_0000_0000;
    fl_m[FL_NEG] = s[39];
    acc_m = s;
    cnt_m++;
  endtask

  // Issue one instruction and compare once it retires or is refused
  task automatic issue(input logic [7:0] opc, input logic [7:0] i, o, m);
    int n;
    logic [31:0] r;
    bit ok;
    r = rnd();
    ok = opc inside {OPC_U_ADD, OPC_U_SUB, OPC_U_RND, OPC_M_ADD, OPC_M_RND};
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= {r[31:24], opc, r[15:8], OPC_PREFIX};
    index_pointer_i <= i;
    operand_pointer_gpr_i <= o;
    move_addr_i <= m;
    if (ok) mdl(opc, ram.mem[i], ram.mem[o]);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (done_o !== 1'b1 && illegal_o !== 1'b1 && n < 8);
    `CHK("illegal", !ok, illegal_o)
    `CHK("acc", acc_m, acc_o)
    `CHK("flags", fl_m, flags_o)
    if (ok) `CHK("move", ram.mem[m], uut.u_ram.mem[m])
  endtask

  initial begin
    {resetn_i, psel_i, penable_i, pwrite_i, instr_valid_i, load_we_i} = '0;
    {paddr_i, pwdata_i, instr_i, index_pointer_i, move_addr_i} = '0;
    {operand_pointer_gpr_i, load_addr_i, load_data_i, acc_m, fl_m} = '0;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    // Reset value of every register, then an unmapped word
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, k < 5 ? 12'(4 * k) : 12'h040, 32'h0000_0000);
      `CHK("rdata", 32'h0000_0000, rd)
      `CHK("slverr", k == 5, er)
    end
    // Fill memory, two all-ones words for the corners
    for (int k = 0; k < 256; k++) begin
      @(posedge clk_sys_i);
      load_we_i <= 1'b1;
      load_addr_i <= 8'(k);
      load_data_i <= k < 2 ? 16'hFFFF : 16'(rnd());
    end
    @(posedge clk_sys_i);
    load_we_i <= 1'b0;
    // Overflow wrapping, then the same case clamped while rounding
    setacc(40'h7F_FFFF_FFFF);
    issue(OPC_U_ADD, 8'h00, 8'h01, 8'h01);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    sat_m = 1'b1;
    setacc(40'h7F_FFFF_FFFF);
    issue(OPC_U_RND, 8'h00, 8'h01, 8'h02);
    // Sticky flags drop only when written with ones
    apb(1'b1, ADDR_FLAGS, 32'h0000_000A);
    fl_m[FL_SLIM] = 1'b0;
    fl_m[FL_SOVF] = 1'b0;
    apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
    `CHK("flag reg", {25'h0, fl_m}, rd)
    setacc(40'h00_0000_0000);
    issue(OPC_U_SUB, 8'h00, 8'h01, 8'h03);
    // Random mix of all forms, clamped first, wrapping later
    for (int k = 0; k < 60; k++) begin
      if (k == 30) apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      if (k == 30) sat_m = 1'b0;
      if (k % 4 == 0) setacc({8'(rnd()), rnd()});
      issue(ops[k % 5], 8'(rnd()), 8'(rnd()), 8'(rnd()));
    end
    issue(8'h38, 8'h04, 8'h05, 8'h06);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK("count", 32'(cnt_m), rd)
    // Accumulator read back, then any write clears the counter
    apb(1'b0, ADDR_ACC_LO, 32'h0000_0000);
    `CHK("acc lo", acc_m[31:0], rd)
    apb(1'b0, ADDR_ACC_HI, 32'h0000_0000);
    `CHK("acc hi", {24'h00_0000, acc_m[39:32]}, rd)
    apb(1'b1, ADDR_COUNT, 32'h0000_0001);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    `CHK("count clr", 32'h0000_0000, rd)
    give_verdict();
  end

  // Watchdog well past the expected run length
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule // mumac_top_tb
